// ===== verilog/hbmpc_policy_ctrl.sv
`timescale 1ns/1ps
`include "hbmpc_cfg.svh"
// Contract
// - Forced mode: flagged writes always auto-precharge
// - Hint mode: precharge from flag and address
// - Enter power-down after long empty queue
// - Default mode: controller schedules all refreshes
// - Sideband refresh requests, all or one bank
// - Policy applies in controller mode; flexible default
// - Ahead policy refreshes early while idle
// - Deferred policy waits for idle or deadline
// - 64B access uses burst length eight
// - 32B access uses burst length four
// - User data path is 256 bits
// - Wide option without ECC or mask: 288 data bits
// - ECC: generate checks, fix single, flag double
// - ECC active means no byte masking
// - Mask option drives per-byte write mask
// - One request port per pseudo channel
module hbmpc_policy_ctrl (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    output logic irq,
    input wire logic [1:0] usr_req_valid,
    input wire hbmpc_pkg::hbmpc_req_t [1:0] usr_req,
    output logic [1:0] usr_req_ack,
    output logic usr_rd_valid,
    output logic usr_rd_pc,
    output logic [287:0] usr_rd_data,
    output logic usr_rd_err,
    output logic mem_cmd_valid,
    output hbmpc_pkg::hbmpc_cmd_t mem_cmd,
    input wire logic mem_cmd_ready,
    input wire logic mem_rd_valid,
    input wire logic mem_rd_pc,
    input wire logic [287:0] mem_rd_data,
    input wire logic sb_ref_req,
    input wire logic sb_ref_all,
    input wire logic [3:0] sb_ref_bank,
    output logic sb_ref_ack
);
    logic [8:0] ctrl_ff;
    logic [3:0] status_ff;
    logic [3:0] irq_mask_ff;
    logic [15:0] pd_idle_ff;
    logic wb_ack_ff;
    logic [31:0] wb_dat_r_ff;
    logic irq_ff;
    hbmpc_pkg::hbmpc_state_t state_ff;
    hbmpc_pkg::hbmpc_state_t nxt_state;
    hbmpc_pkg::hbmpc_cmd_t mem_cmd_ff;
    hbmpc_pkg::hbmpc_cmd_t nxt_cmd;
    logic mem_cmd_valid_ff;
    logic nxt_cmd_valid;
    logic [1:0] usr_req_ack_ff;
    logic rr_ff;
    logic [15:0] idle_cnt_ff;
    logic [11:0] ref_cnt_ff;
    logic [3:0] owed_ff;
    logic [3:0] ahead_ff;
    logic [3:0] nxt_owed;
    logic [3:0] nxt_ahead;
    logic sb_pend_ff;
    logic sb_all_ff;
    logic [3:0] sb_bank_ff;
    logic sb_ref_ack_ff;
    logic usr_rd_valid_ff;
    logic usr_rd_pc_ff;
    logic [287:0] usr_rd_data_ff;
    logic usr_rd_err_ff;

    // Register bus decode
    wire wb_req = wb_cyc && wb_stb && !wb_ack_ff;
    wire wb_wr = wb_req && wb_we;
    wire hit_ctrl = wb_adr == `HBMPC_ADR_CTRL;
    wire hit_status = wb_adr == `HBMPC_ADR_STATUS;
    wire hit_mask = wb_adr == `HBMPC_ADR_MASK;
    wire hit_state = wb_adr == `HBMPC_ADR_STATE;
    wire hit_pd_idle = wb_adr == `HBMPC_ADR_PD_IDLE;
    wire [31:0] wb_bmask = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
    wire [31:0] wb_wdat = wb_dat_w & wb_bmask;

    wire wap_hint = ctrl_ff[`HBMPC_CTRL_WAP_HINT];
    wire pd_en = ctrl_ff[`HBMPC_CTRL_PD_EN];
    wire sb_mode = ctrl_ff[`HBMPC_CTRL_REF_SB];
    wire [1:0] pol = ctrl_ff[`HBMPC_CTRL_POL_LSB +: 2];
    wire bl8 = ctrl_ff[`HBMPC_CTRL_BL8];
    wire ecc_en = ctrl_ff[`HBMPC_CTRL_ECC];
    wire mask_on = ctrl_ff[`HBMPC_CTRL_WMASK] && !ecc_en;
    wire wide_on = ctrl_ff[`HBMPC_CTRL_WIDE] && !ecc_en && !ctrl_ff[`HBMPC_CTRL_WMASK];
    wire in_pd = state_ff == hbmpc_pkg::HBMPC_ST_PD;
    wire run = state_ff == hbmpc_pkg::HBMPC_ST_RUN;

    // Requests, masked while the previous one is being acknowledged
    wire [1:0] req_avail = usr_req_valid & ~usr_req_ack_ff;
    wire req_go = |req_avail;
    wire pick = req_avail[rr_ff] ? rr_ff : ~rr_ff;
    wire hbmpc_pkg::hbmpc_req_t sel_req = usr_req[pick];
    wire col_last = sel_req.addr[`HBMPC_COL_LSB +: 5] == `HBMPC_COL_LAST;
    // Hint keeps the row open until the stream leaves its last column
    wire wr_ap = wap_hint ? (sel_req.ap && col_last) : sel_req.ap;
    wire cmd_free = !mem_cmd_valid_ff || mem_cmd_ready;

    // Refresh scheduling
    wire ref_tick = ref_cnt_ff == 12'(`HBMPC_TREFI_CYC - 1) && !sb_mode;
    wire [3:0] force_lim = (pol == hbmpc_pkg::HBMPC_POL_POSTPAY) ?
        `HBMPC_POST_LIMIT : `HBMPC_FLEX_LIMIT;
    wire ref_force = owed_ff >= force_lim;
    wire pre_room = pol == hbmpc_pkg::HBMPC_POL_PREPAY && ahead_ff < `HBMPC_PRE_LIMIT;
    wire ref_soft = owed_ff != 4'h0 || pre_room;
    wire ref_go = sb_mode ? sb_pend_ff : (ref_force || (ref_soft && !req_go));
    wire ref_due = sb_mode ? sb_pend_ff : owed_ff != 4'h0;

    // Power-down
    wire pd_go = pd_en && idle_cnt_ff >= pd_idle_ff && !req_go;
    wire idle_now = run && !req_go && !mem_cmd_valid_ff && !ref_go;
    wire wake = req_go || ref_due;

    wire issue_pdx = cmd_free && in_pd && wake;
    wire issue_ref = cmd_free && run && ref_go;
    wire issue_req = cmd_free && run && !ref_go && req_go;
    wire issue_pde = cmd_free && run && !ref_go && !req_go && pd_go;

    // ECC lanes
    wire [31:0] enc_chk;
    wire [255:0] dec_fixed;
    wire [3:0] dec_sbe;
    wire [3:0] dec_dbe;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            hbmpc_secded u_secded (
                .enc_data(sel_req.data[g * 64 +: 64]),
                .enc_check(enc_chk[g * 8 +: 8]),
                .dec_data(mem_rd_data[g * 64 +: 64]),
                .dec_check(mem_rd_data[256 + g * 8 +: 8]),
                .dec_fixed(dec_fixed[g * 64 +: 64]),
                .dec_sbe(dec_sbe[g]),
                .dec_dbe(dec_dbe[g])
            );
        end
    endgenerate

    // Upper 32 lanes carry checks, user data in wide mode, or zero
    wire [31:0] wr_hi = ecc_en ? enc_chk : (wide_on ? sel_req.data[287:256] : 32'h0);
    wire [31:0] wr_mask = mask_on ? ~sel_req.strb : 32'h0;
    wire [287:0] rd_out = ecc_en ? {32'h0, dec_fixed} :
        (wide_on ? mem_rd_data : {32'h0, mem_rd_data[255:0]});
    wire rd_sbe_ev = mem_rd_valid && ecc_en && |dec_sbe && !(|dec_dbe);
    wire rd_dbe_ev = mem_rd_valid && ecc_en && |dec_dbe;
    wire [3:0] events = {issue_ref, issue_pde, rd_dbe_ev, rd_sbe_ev};
    wire [3:0] st_clr = (wb_wr && hit_status) ? wb_wdat[3:0] : 4'h0;
    // Set wins over a clear in the same cycle
    wire [3:0] nxt_status = (status_ff & ~st_clr) | events;
    wire [31:0] state_word = {19'h0, sb_pend_ff, ahead_ff, owed_ff, 3'h0, in_pd};
    wire [31:0] rd_mux = hit_ctrl ? {23'h0, ctrl_ff} :
        hit_status ? {28'h0, status_ff} :
        hit_mask ? {28'h0, irq_mask_ff} :
        hit_state ? state_word :
        hit_pd_idle ? {16'h0, pd_idle_ff} : 32'h0;
    wire [3:0] wb_sel_burst = bl8 ? `HBMPC_BL8 : `HBMPC_BL4;
    wire sb_take = sb_mode && sb_ref_req && !sb_pend_ff && !sb_ref_ack_ff;

    always_comb begin
        nxt_owed = owed_ff;
        nxt_ahead = ahead_ff;
        if (sb_mode) begin
            nxt_owed = 4'h0;
            nxt_ahead = 4'h0;
        end else begin
            if (ref_tick) begin
                if (nxt_ahead != 4'h0) begin
                    nxt_ahead = nxt_ahead - 4'h1;
                end else if (nxt_owed != 4'hF) begin
                    nxt_owed = nxt_owed + 4'h1;
                end
            end
            if (issue_ref) begin
                if (nxt_owed != 4'h0) begin
                    nxt_owed = nxt_owed - 4'h1;
                end else begin
                    nxt_ahead = nxt_ahead + 4'h1;
                end
            end
        end
    end

    always_comb begin
        nxt_cmd = mem_cmd_ff;
        nxt_cmd_valid = mem_cmd_valid_ff && !mem_cmd_ready;
        nxt_state = state_ff;
        if (cmd_free) begin
            nxt_cmd = '0;
            nxt_cmd.op = hbmpc_pkg::HBMPC_OP_NOP;
        end
        if (issue_pdx) begin
            nxt_cmd.op = hbmpc_pkg::HBMPC_OP_PDX;
            nxt_cmd_valid = 1'h1;
            nxt_state = hbmpc_pkg::HBMPC_ST_RUN;
        end else if (issue_ref) begin
            nxt_cmd.op = hbmpc_pkg::HBMPC_OP_REF;
            nxt_cmd.all_banks = sb_mode ? sb_all_ff : 1'h1;
            nxt_cmd.bank = sb_mode ? sb_bank_ff : 4'h0;
            nxt_cmd_valid = 1'h1;
        end else if (issue_req) begin
            nxt_cmd.op = sel_req.write ? hbmpc_pkg::HBMPC_OP_WR : hbmpc_pkg::HBMPC_OP_RD;
            nxt_cmd.pc = pick;
            nxt_cmd.ap = sel_req.write ? wr_ap : sel_req.ap;
            nxt_cmd.burst_len = wb_sel_burst;
            nxt_cmd.addr = sel_req.addr;
            if (sel_req.write) begin
                nxt_cmd.data = {wr_hi, sel_req.data[255:0]};
                nxt_cmd.mask = wr_mask;
            end
            nxt_cmd_valid = 1'h1;
        end else if (issue_pde) begin
            nxt_cmd.op = hbmpc_pkg::HBMPC_OP_PDE;
            nxt_cmd_valid = 1'h1;
            nxt_state = hbmpc_pkg::HBMPC_ST_PD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_ff <= `HBMPC_CTRL_RST;
            irq_mask_ff <= `HBMPC_MASK_RST;
            pd_idle_ff <= `HBMPC_PD_IDLE_RST;
        end else if (wb_wr) begin
            if (hit_ctrl) begin
                ctrl_ff <= (ctrl_ff & ~wb_bmask[8:0]) | wb_wdat[8:0];
            end
            if (hit_mask) begin
                irq_mask_ff <= (irq_mask_ff & ~wb_bmask[3:0]) | wb_wdat[3:0];
            end
            if (hit_pd_idle) begin
                pd_idle_ff <= (pd_idle_ff & ~wb_bmask[15:0]) | wb_wdat[15:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_ff <= `HBMPC_STATUS_RST;
            irq_ff <= 1'h0;
            wb_ack_ff <= 1'h0;
            wb_dat_r_ff <= 32'h0;
        end else begin
            status_ff <= nxt_status;
            irq_ff <= |(nxt_status & irq_mask_ff);
            wb_ack_ff <= wb_req;
            wb_dat_r_ff <= wb_req ? rd_mux : wb_dat_r_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_ff <= hbmpc_pkg::HBMPC_ST_RUN;
            mem_cmd_ff <= '0;
            mem_cmd_valid_ff <= 1'h0;
            usr_req_ack_ff <= 2'h0;
            rr_ff <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            mem_cmd_ff <= nxt_cmd;
            mem_cmd_valid_ff <= nxt_cmd_valid;
            usr_req_ack_ff <= issue_req ? {pick, ~pick} : 2'h0;
            rr_ff <= issue_req ? ~pick : rr_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            idle_cnt_ff <= 16'h0;
            ref_cnt_ff <= 12'h0;
            owed_ff <= 4'h0;
            ahead_ff <= 4'h0;
        end else begin
            idle_cnt_ff <= (idle_now && idle_cnt_ff != 16'hFFFF) ? idle_cnt_ff + 16'h1 :
                (idle_now ? idle_cnt_ff : 16'h0);
            ref_cnt_ff <= (ref_cnt_ff == 12'(`HBMPC_TREFI_CYC - 1)) ? 12'h0 : ref_cnt_ff + 12'h1;
            owed_ff <= nxt_owed;
            ahead_ff <= nxt_ahead;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sb_pend_ff <= 1'h0;
            sb_all_ff <= 1'h0;
            sb_bank_ff <= 4'h0;
            sb_ref_ack_ff <= 1'h0;
        end else begin
            sb_pend_ff <= sb_take || (sb_pend_ff && !issue_ref && sb_mode);
            sb_all_ff <= sb_take ? sb_ref_all : sb_all_ff;
            sb_bank_ff <= sb_take ? sb_ref_bank : sb_bank_ff;
            sb_ref_ack_ff <= issue_ref && sb_mode;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            usr_rd_valid_ff <= 1'h0;
            usr_rd_pc_ff <= 1'h0;
            usr_rd_data_ff <= '0;
            usr_rd_err_ff <= 1'h0;
        end else begin
            usr_rd_valid_ff <= mem_rd_valid;
            usr_rd_pc_ff <= mem_rd_valid ? mem_rd_pc : usr_rd_pc_ff;
            usr_rd_data_ff <= mem_rd_valid ? rd_out : usr_rd_data_ff;
            usr_rd_err_ff <= rd_dbe_ev;
        end
    end

    assign wb_dat_r = wb_dat_r_ff;
    assign wb_ack = wb_ack_ff;
    assign irq = irq_ff;
    assign usr_req_ack = usr_req_ack_ff;
    assign usr_rd_valid = usr_rd_valid_ff;
    assign usr_rd_pc = usr_rd_pc_ff;
    assign usr_rd_data = usr_rd_data_ff;
    assign usr_rd_err = usr_rd_err_ff;
    assign mem_cmd_valid = mem_cmd_valid_ff;
    assign mem_cmd = mem_cmd_ff;
    assign sb_ref_ack = sb_ref_ack_ff;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence s_req_write;
        issue_req && sel_req.write;
    endsequence
    sequence s_pd_wake;
        in_pd && wake && cmd_free;
    endsequence

    forced_ap_a: assert property (s_req_write ##0 (sel_req.ap && !wap_hint) |=> mem_cmd_ff.ap)
        else $error("forced write lost its auto-precharge");
    hint_ap_a: assert property (s_req_write ##0 wap_hint |=>
        mem_cmd_ff.ap == $past(sel_req.ap && col_last))
        else $error("hint precharge decision wrong");
    pd_entry_a: assert property (issue_pde |-> pd_en && idle_cnt_ff >= pd_idle_ff ##1
        mem_cmd_valid_ff && mem_cmd_ff.op == hbmpc_pkg::HBMPC_OP_PDE && in_pd)
        else $error("power-down entry not after idle interval");
    pd_wake_a: assert property (s_pd_wake |=>
        mem_cmd_ff.op == hbmpc_pkg::HBMPC_OP_PDX && run)
        else $error("power-down not left on wake");
    ref_deadline_a: assert property (!sb_mode && run && cmd_free && owed_ff >= force_lim |=>
        mem_cmd_valid_ff && mem_cmd_ff.op == hbmpc_pkg::HBMPC_OP_REF)
        else $error("due refresh not issued");
    post_defer_a: assert property (!sb_mode && pol == hbmpc_pkg::HBMPC_POL_POSTPAY && req_go &&
        owed_ff < `HBMPC_POST_LIMIT && cmd_free |=> mem_cmd_ff.op != hbmpc_pkg::HBMPC_OP_REF)
        else $error("deferred refresh issued too early");
    prepay_a: assert property (!sb_mode && pre_room && run && cmd_free && !req_go |=>
        mem_cmd_ff.op == hbmpc_pkg::HBMPC_OP_REF)
        else $error("idle ahead refresh missing");
    sb_ref_a: assert property (sb_mode && sb_pend_ff && run && cmd_free |=>
        mem_cmd_ff.op == hbmpc_pkg::HBMPC_OP_REF && sb_ref_ack_ff &&
        mem_cmd_ff.all_banks == $past(sb_all_ff) && mem_cmd_ff.bank == $past(sb_bank_ff))
        else $error("sideband refresh not carried out");
    burst_len_a: assert property (issue_req |=>
        mem_cmd_ff.burst_len == ($past(bl8) ? 4'h8 : 4'h4))
        else $error("burst length does not follow access size");
    ecc_mask_a: assert property (issue_req && ecc_en |=> mem_cmd_ff.mask == 32'h0)
        else $error("byte mask applied with ECC");
    err_sticky_a: assert property (rd_dbe_ev |=> status_ff[`HBMPC_EV_DBE] && usr_rd_err_ff)
        else $error("uncorrectable error not reported");
endmodule

// ===== verilog/hbmpc_cfg.svh
`ifndef HBMPC_CFG_SVH
`define HBMPC_CFG_SVH
`define HBMPC_ADR_CTRL 8'h00
`define HBMPC_ADR_STATUS 8'h04
`define HBMPC_ADR_MASK 8'h08
`define HBMPC_ADR_STATE 8'h0C
`define HBMPC_ADR_PD_IDLE 8'h10
`define HBMPC_CTRL_WAP_HINT 0
`define HBMPC_CTRL_PD_EN 1
`define HBMPC_CTRL_REF_SB 2
`define HBMPC_CTRL_POL_LSB 3
`define HBMPC_CTRL_BL8 5
`define HBMPC_CTRL_ECC 6
`define HBMPC_CTRL_WMASK 7
`define HBMPC_CTRL_WIDE 8
`define HBMPC_CTRL_RST 9'h000
`define HBMPC_EV_SBE 0
`define HBMPC_EV_DBE 1
`define HBMPC_EV_PDE 2
`define HBMPC_EV_REF 3
`define HBMPC_STATUS_RST 4'h0
`define HBMPC_MASK_RST 4'h0
`define HBMPC_PD_IDLE_RST 16'h0100
`define HBMPC_COL_LSB 0
`define HBMPC_COL_LAST 5'h1F
`define HBMPC_CLK_NS 40
`define HBMPC_TREFI_NS 3900
`define HBMPC_TREFI_CYC (`HBMPC_TREFI_NS / `HBMPC_CLK_NS)
`define HBMPC_FLEX_LIMIT 4'h2
`define HBMPC_POST_LIMIT 4'h8
`define HBMPC_PRE_LIMIT 4'h8
`define HBMPC_BL8 4'h8
`define HBMPC_BL4 4'h4
`endif

// ===== verilog/hbmpc_pkg.sv
package hbmpc_pkg;
    typedef enum logic [2:0] {
        HBMPC_OP_NOP = 3'h0,
        HBMPC_OP_RD = 3'h1,
        HBMPC_OP_WR = 3'h2,
        HBMPC_OP_REF = 3'h3,
        HBMPC_OP_PDE = 3'h4,
        HBMPC_OP_PDX = 3'h5
    } hbmpc_op_t;
    typedef enum logic [1:0] {
        HBMPC_ST_RUN = 2'h1,
        HBMPC_ST_PD = 2'h2
    } hbmpc_state_t;
    typedef enum logic [1:0] {
        HBMPC_POL_FLEX = 2'h0,
        HBMPC_POL_PREPAY = 2'h1,
        HBMPC_POL_POSTPAY = 2'h2
    } hbmpc_pol_t;
    typedef struct packed {
        logic write;
        logic ap;
        logic [27:0] addr;
        logic [287:0] data;
        logic [31:0] strb;
    } hbmpc_req_t;
    typedef struct packed {
        hbmpc_op_t op;
        logic pc;
        logic ap;
        logic [3:0] burst_len;
        logic all_banks;
        logic [3:0] bank;
        logic [27:0] addr;
        logic [287:0] data;
        logic [31:0] mask;
    } hbmpc_cmd_t;
endpackage

// ===== verilog/hbmpc_secded.sv
`timescale 1ns/1ps
// Hamming 72/64 lane: check bits at power-of-two positions, bit 7 overall parity
module hbmpc_secded (
    input wire logic [63:0] enc_data,
    output logic [7:0] enc_check,
    input wire logic [63:0] dec_data,
    input wire logic [7:0] dec_check,
    output logic [63:0] dec_fixed,
    output logic dec_sbe,
    output logic dec_dbe
);
    always_comb begin
        logic [71:1] cw;
        logic par;
        int k;
        cw = '0;
        par = 1'h0;
        k = 0;
        for (int i = 1; i < 72; i++) begin
            if ((i & (i - 1)) != 0) begin
                cw[i] = enc_data[k];
                k++;
            end
        end
        for (int j = 0; j < 7; j++) begin
            par = 1'h0;
            for (int i = 1; i < 72; i++) begin
                if (i[j]) begin
                    par = par ^ cw[i];
                end
            end
            enc_check[j] = par;
        end
        enc_check[7] = (^enc_data) ^ (^enc_check[6:0]);
    end

    always_comb begin
        logic [71:1] cw;
        logic [6:0] syn;
        logic odd;
        int k;
        cw = '0;
        syn = '0;
        k = 0;
        for (int i = 1; i < 72; i++) begin
            if ((i & (i - 1)) != 0) begin
                cw[i] = dec_data[k];
                k++;
            end
        end
        for (int j = 0; j < 7; j++) begin
            cw[1 << j] = dec_check[j];
        end
        for (int j = 0; j < 7; j++) begin
            for (int i = 1; i < 72; i++) begin
                if (i[j]) begin
                    syn[j] = syn[j] ^ cw[i];
                end
            end
        end
        odd = (^dec_data) ^ (^dec_check);
        dec_sbe = 1'h0;
        dec_dbe = 1'h0;
        if (syn != 7'h00 && odd && syn < 7'h48) begin
            cw[syn] = ~cw[syn];
            dec_sbe = 1'h1;
        end else if (syn != 7'h00) begin
            dec_dbe = 1'h1;
        end else if (odd) begin
            dec_sbe = 1'h1;
        end
        k = 0;
        dec_fixed = '0;
        for (int i = 1; i < 72; i++) begin
            if ((i & (i - 1)) != 0) begin
                dec_fixed[k] = cw[i];
                k++;
            end
        end
    end
endmodule

// ===== tb/hbmpc_mem_model.sv
`timescale 1ns/1ps
module hbmpc_mem_model (
    input wire logic clk_sys,
    input wire logic slow,
    input wire logic mem_cmd_valid,
    input wire hbmpc_pkg::hbmpc_cmd_t mem_cmd,
    output logic mem_cmd_ready,
    output logic mem_rd_valid,
    output logic mem_rd_pc,
    output logic [287:0] mem_rd_data,
    output hbmpc_pkg::hbmpc_cmd_t last_cmd,
    output hbmpc_pkg::hbmpc_cmd_t last_ref,
    output hbmpc_pkg::hbmpc_op_t prev_op,
    output logic [7:0] n_cmd,
    output logic [7:0] n_ref
);
    logic tog_ff = 1'h0;
    wire take = mem_cmd_valid && mem_cmd_ready;
    wire is_ref = mem_cmd.op == hbmpc_pkg::HBMPC_OP_REF;
    // Slow mode accepts only every other cycle
    assign mem_cmd_ready = !slow || tog_ff;
    initial begin
        mem_rd_valid = 1'h0;
        mem_rd_pc = 1'h0;
        mem_rd_data = '0;
        last_cmd = '0;
        last_ref = '0;
        prev_op = hbmpc_pkg::HBMPC_OP_NOP;
        n_cmd = 8'h00;
        n_ref = 8'h00;
    end
    always @(posedge clk_sys) begin
        tog_ff <= !tog_ff;
        mem_rd_valid <= 1'h0;
        // Released data lines keep flipping so stale data never matches
        mem_rd_data <= ~mem_rd_data;
        if (take && is_ref) begin
            last_ref <= mem_cmd;
            n_ref <= n_ref + 8'h01;
        end
        if (take && !is_ref) begin
            prev_op <= last_cmd.op;
            last_cmd <= mem_cmd;
            n_cmd <= n_cmd + 8'h01;
        end
        if (take && mem_cmd.op == hbmpc_pkg::HBMPC_OP_RD) begin
            mem_rd_valid <= 1'h1;
            mem_rd_pc <= mem_cmd.pc;
            mem_rd_data <= {32'hA5A5A5A5, {8{4'h0, mem_cmd.addr}}};
        end
    end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [287:0] DAT = {9{32'h5A5AC3C3}};
    logic clk_sys, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, irq, slow;
    logic [7:0] wb_adr, n_cmd, n_ref, n_rd;
    logic [3:0] wb_sel, sb_ref_bank;
    logic [31:0] wb_dat_w, wb_dat_r, rq;
    logic usr_rd_valid, usr_rd_pc, usr_rd_err, mem_cmd_valid, mem_cmd_ready;
    logic mem_rd_valid, mem_rd_pc, sb_ref_req, sb_ref_all, sb_ref_ack;
    logic [1:0] usr_req_valid, usr_req_ack;
    hbmpc_pkg::hbmpc_req_t [1:0] usr_req;
    logic [287:0] usr_rd_data, mem_rd_data, rd_last;
    hbmpc_pkg::hbmpc_cmd_t mem_cmd, last_cmd, last_ref;
    hbmpc_pkg::hbmpc_op_t prev_op;
    int bad_count, n_checks;
    hbmpc_policy_ctrl dut_u (.*);
    hbmpc_mem_model mem_u (.*);
    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = !clk_sys;
    end
    always @(posedge clk_sys) begin
        if (usr_rd_valid === 1'h1) begin
            n_rd <= n_rd + 8'h01;
            rd_last <= usr_rd_data;
        end
    end
    task automatic chk(input string what, input logic [287:0] exp, input logic [287:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'h1 && n < 50);
        rq = wb_dat_r;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        if (n >= 50) bad_count++;
    endtask
    task automatic req(input int pc, input logic w, input logic ap, input logic [27:0] a,
            input logic [31:0] strb);
        int n = 0;
        logic [7:0] c0 = n_cmd;
        hbmpc_pkg::hbmpc_op_t op = w ? hbmpc_pkg::HBMPC_OP_WR : hbmpc_pkg::HBMPC_OP_RD;
        @(posedge clk_sys);
        usr_req_valid[pc] <= 1'h1;
        usr_req[pc] <= {w, ap, a, DAT, strb};
        do begin
            @(posedge clk_sys);
            n++;
        end while (usr_req_ack[pc] !== 1'h1 && n < 500);
        usr_req_valid[pc] <= 1'h0;
        while ((n_cmd == c0 || last_cmd.op != op) && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 500) bad_count++;
    endtask
    task automatic t_regs();
        wb(1'h1, 8'h14, 32'hFFFFFFFF);
        wb(1'h0, 8'h00, 32'h0); chk("ctrl", 32'h0, rq);
        wb(1'h0, 8'h08, 32'h0); chk("mask", 32'h0, rq);
        wb(1'h0, 8'h10, 32'h0); chk("pd_idle", 32'h100, rq);
        wb(1'h0, 8'h14, 32'h0); chk("unmapped", 32'h0, rq);
        repeat (250) @(posedge clk_sys);
        chk("ref_all", 1'h1, last_ref.all_banks);
        wb(1'h0, 8'h04, 32'h0); chk("st_ref", 1'h1, rq[3]);
        chk("irq_masked", 1'h0, irq);
        wb(1'h1, 8'h08, 32'h8);
        wb(1'h0, 8'h08, 32'h0); chk("irq_on", 1'h1, irq);
        wb(1'h1, 8'h08, 32'h0);
        // Idle pre-pay banks credits up to the limit; a tick may take one back
        wb(1'h1, 8'h00, 32'h8);
        repeat (30) @(posedge clk_sys);
        wb(1'h0, 8'h0C, 32'h0); chk("ahead", 1'h1, rq[11:8] >= 4'h7);
    endtask
    task automatic t_write();
        wb(1'h1, 8'h00, 32'h0);
        req(0, 1'h1, 1'h1, 28'h5, 32'hFFFFFFFF);
        chk("ap_forced", 1'h1, last_cmd.ap);
        chk("bl4", 4'h4, last_cmd.burst_len);
        chk("wdata", {32'h0, DAT[255:0]}, last_cmd.data);
        wb(1'h1, 8'h00, 32'h21);
        req(1, 1'h1, 1'h1, 28'h5, 32'hFFFFFFFF);
        chk("ap_hint_mid", 1'h0, last_cmd.ap);
        chk("bl8", 4'h8, last_cmd.burst_len);
        chk("pc1", 1'h1, last_cmd.pc);
        req(1, 1'h1, 1'h1, 28'h1F, 32'hFFFFFFFF);
        chk("ap_hint_end", 1'h1, last_cmd.ap);
        wb(1'h1, 8'h00, 32'h80);
        req(0, 1'h1, 1'h0, 28'h10, 32'h0000FFFF);
        chk("wmask", 32'hFFFF0000, last_cmd.mask);
        wb(1'h1, 8'h00, 32'hC0);
        req(0, 1'h1, 1'h0, 28'h10, 32'h0000FFFF);
        chk("wmask_ecc", 32'h0, last_cmd.mask);
        wb(1'h1, 8'h00, 32'h100);
        req(0, 1'h1, 1'h0, 28'h10, 32'hFFFFFFFF);
        chk("wdata_wide", DAT, last_cmd.data);
    endtask
    task automatic t_read();
        int n;
        logic [7:0] c;
        for (int i = 0; i < 2; i++) begin
            wb(1'h1, 8'h00, i ? 32'h100 : 32'h0);
            // Second pass stalls the command slot as well
            slow <= i[0];
            c = n_rd;
            n = 0;
            req(i, 1'h0, 1'h0, 28'hABCDEF, 32'h0);
            while (n_rd == c && n < 50) begin
                @(posedge clk_sys);
                n++;
            end
            chk("rdata", {i ? 32'hA5A5A5A5 : 32'h0, {8{32'h0ABCDEF}}}, rd_last);
            chk("rd_pc", i, usr_rd_pc);
        end
        slow <= 1'h0;
    endtask
    task automatic t_side();
        int n;
        wb(1'h1, 8'h00, 32'h4);
        for (int j = 0; j < 2; j++) begin
            n = 0;
            @(posedge clk_sys);
            sb_ref_req <= 1'h1;
            sb_ref_all <= j[0];
            sb_ref_bank <= 4'h5;
            do begin
                @(posedge clk_sys);
                n++;
            end while (sb_ref_ack !== 1'h1 && n < 100);
            sb_ref_req <= 1'h0;
            chk("sb_ack", 1'h1, sb_ref_ack);
            // Model logged the command on the edge that showed the ack; it is readable after one more edge
            @(posedge clk_sys);
            chk("sb_tgt", {j[0], 4'h5}, {last_ref.all_banks, last_ref.bank});
        end
    endtask
    task automatic t_pd();
        int n = 0;
        wb(1'h1, 8'h10, 32'h40);
        wb(1'h1, 8'h08, 32'h4);
        wb(1'h1, 8'h04, 32'hF);
        wb(1'h1, 8'h00, 32'h2);
        while (last_cmd.op != hbmpc_pkg::HBMPC_OP_PDE && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
        chk("pd_entry", hbmpc_pkg::HBMPC_OP_PDE, last_cmd.op);
        chk("irq_pd", 1'h1, irq);
        wb(1'h1, 8'h04, 32'h4);
        chk("irq_clr", 1'h0, irq);
        req(0, 1'h1, 1'h0, 28'h3, 32'hFFFFFFFF);
        chk("pd_exit", hbmpc_pkg::HBMPC_OP_PDX, prev_op);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #800000;
        bad_count++;
        close_out();
    end
    initial begin
        sys_rst = 1'h1;
        {wb_cyc, wb_stb, wb_we, slow, sb_ref_req, sb_ref_all} = 6'h00;
        wb_adr = 8'h00;
        wb_sel = 4'hF;
        wb_dat_w = 32'h0;
        sb_ref_bank = 4'h0;
        usr_req_valid = 2'h0;
        usr_req = '0;
        n_rd = 8'h00;
        rd_last = '0;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'h0;
        t_regs();
        t_write();
        t_read();
        t_side();
        t_pd();
        close_out();
    end
endmodule
